//--- rtl/sbdsk_pkg.sv
// shared types and constants for the subtract-borrow / decrement-skip unit
package sbdsk_pkg;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_ONE = 8'h01;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam int unsigned NIB_W = 4;
    localparam int unsigned SIGN_BIT = 7;

    typedef enum logic [1:0] {
        SBDSK_OP_NONE = 2'h0,
        SBDSK_OP_SUB_ACC = 2'h1,
        SBDSK_OP_SUB_MEM = 2'h2,
        SBDSK_OP_DEC_SKIP = 2'h3
    } sbdsk_op_e;

    typedef enum logic [1:0] {
        SBDSK_ST_IDLE = 2'h0,
        SBDSK_ST_WRITE = 2'h1,
        SBDSK_ST_DUMMY = 2'h2
    } sbdsk_state_e;

    // status flags held by the core; this unit updates them
    typedef struct packed {
        logic overflow_flag;
        logic zero_flag;
        logic auxiliary_carry_flag;
        logic carry_flag;
    } sbdsk_flags_s;

    // instruction request from the decoder, with the operand already read
    typedef struct packed {
        logic valid;
        sbdsk_op_e op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] operand;
    } sbdsk_req_s;

    // write request towards data memory
    typedef struct packed {
        logic we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } sbdsk_mem_wr_s;

    // result of one subtraction
    typedef struct packed {
        logic [DATA_W-1:0] diff;
        sbdsk_flags_s flags;
    } sbdsk_alu_s;
endpackage

//--- rtl/sbdsk_sub_alu.sv
// 8-bit subtract-with-borrow core with flag generation
`timescale 1ns/1ps
`default_nettype none
module sbdsk_sub_alu (
    input wire logic [7:0] minuend,
    input wire logic [7:0] subtrahend,
    input wire logic carry_in,
    output sbdsk_pkg::sbdsk_alu_s result
);
    logic [sbdsk_pkg::DATA_W:0] full;
    logic [sbdsk_pkg::NIB_W:0] low;
    logic borrow_in;

    always_comb begin
        // borrow is the complement of carry
        borrow_in = ~carry_in;
        full = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, borrow_in};
        low = {1'b0, minuend[sbdsk_pkg::NIB_W-1:0]}
            - {1'b0, subtrahend[sbdsk_pkg::NIB_W-1:0]} - {4'h0, borrow_in};
        result.diff = full[sbdsk_pkg::DATA_W-1:0];
        // carry set when no borrow out, i.e. result not negative
        result.flags.carry_flag = ~full[sbdsk_pkg::DATA_W];
        result.flags.auxiliary_carry_flag = ~low[sbdsk_pkg::NIB_W];
        result.flags.zero_flag = (full[sbdsk_pkg::DATA_W-1:0] == sbdsk_pkg::BYTE_ZERO);
        result.flags.overflow_flag = (minuend[sbdsk_pkg::SIGN_BIT]
            ^ subtrahend[sbdsk_pkg::SIGN_BIT])
            & (minuend[sbdsk_pkg::SIGN_BIT] ^ full[sbdsk_pkg::SIGN_BIT]);
    end
endmodule
`default_nettype wire

//--- rtl/sbdsk_unit.sv
// execution unit for subtract-with-borrow and decrement-skip instructions
`timescale 1ns/1ps
`default_nettype none
module sbdsk_unit (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire sbdsk_pkg::sbdsk_req_s req,
    output logic busy,
    output logic done,
    output logic skip_next,
    output logic [7:0] acc,
    output sbdsk_pkg::sbdsk_flags_s flags,
    output sbdsk_pkg::sbdsk_mem_wr_s mem_wr
);
    typedef struct packed {
        sbdsk_pkg::sbdsk_state_e state;
        logic busy;
        logic done;
        logic skip_next;
        logic [7:0] acc;
        sbdsk_pkg::sbdsk_flags_s flags;
        sbdsk_pkg::sbdsk_mem_wr_s mem_wr;
    } sbdsk_core_s;

    sbdsk_core_s st_reg;
    sbdsk_core_s st_next;
    sbdsk_pkg::sbdsk_alu_s alu;
    logic [7:0] dec_val;

    sbdsk_sub_alu u_alu (
        .minuend(st_reg.acc),
        .subtrahend(req.operand),
        .carry_in(st_reg.flags.carry_flag),
        .result(alu)
    );

    always_comb begin
        st_next = st_reg;
        st_next.done = 1'b0;
        st_next.skip_next = 1'b0;
        st_next.mem_wr.we = 1'b0;
        dec_val = req.operand - sbdsk_pkg::BYTE_ONE;
        case (st_reg.state)
            sbdsk_pkg::SBDSK_ST_IDLE: begin
                if (req.valid) begin
                    case (req.op)
                        sbdsk_pkg::SBDSK_OP_SUB_ACC: begin
                            st_next.acc = alu.diff;
                            st_next.flags = alu.flags;
                            st_next.done = 1'b1;
                        end
                        sbdsk_pkg::SBDSK_OP_SUB_MEM: begin
                            st_next.mem_wr.we = 1'b1;
                            st_next.mem_wr.addr = req.addr;
                            st_next.mem_wr.wdata = alu.diff;
                            st_next.flags = alu.flags;
                            st_next.done = 1'b1;
                        end
                        sbdsk_pkg::SBDSK_OP_DEC_SKIP: begin
                            // flags untouched
                            st_next.mem_wr.we = 1'b1;
                            st_next.mem_wr.addr = req.addr;
                            st_next.mem_wr.wdata = dec_val;
                            if (dec_val == sbdsk_pkg::BYTE_ZERO) begin
                                st_next.skip_next = 1'b1;
                                st_next.busy = 1'b1;
                                st_next.state = sbdsk_pkg::SBDSK_ST_DUMMY;
                            end else begin
                                st_next.done = 1'b1;
                            end
                        end
                        default: begin
                            st_next.state = sbdsk_pkg::SBDSK_ST_IDLE;
                        end
                    endcase
                end
            end
            sbdsk_pkg::SBDSK_ST_DUMMY: begin
                // dummy cycle while the skipped instruction is fetched
                st_next.busy = 1'b0;
                st_next.done = 1'b1;
                st_next.state = sbdsk_pkg::SBDSK_ST_IDLE;
            end
            default: begin
                st_next.busy = 1'b0;
                st_next.state = sbdsk_pkg::SBDSK_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign busy = st_reg.busy;
    assign done = st_reg.done;
    assign skip_next = st_reg.skip_next;
    assign acc = st_reg.acc;
    assign flags = st_reg.flags;
    assign mem_wr = st_reg.mem_wr;

    logic [8:0] chk_full;
    assign chk_full = {1'b0, st_reg.acc} - {1'b0, req.operand}
        - {8'h00, ~st_reg.flags.carry_flag};

    wire accept = req.valid && st_reg.state == sbdsk_pkg::SBDSK_ST_IDLE;

    // flag reference built apart from the alu
    logic [sbdsk_pkg::NIB_W:0] chk_low;
    logic chk_ovf;
    logic is_sub;
    assign chk_low = {1'b0, st_reg.acc[sbdsk_pkg::NIB_W-1:0]}
        - {1'b0, req.operand[sbdsk_pkg::NIB_W-1:0]}
        - {4'h0, ~st_reg.flags.carry_flag};
    assign chk_ovf = (st_reg.acc[sbdsk_pkg::SIGN_BIT] != req.operand[sbdsk_pkg::SIGN_BIT])
        && (chk_full[sbdsk_pkg::SIGN_BIT] != st_reg.acc[sbdsk_pkg::SIGN_BIT]);
    assign is_sub = req.op == sbdsk_pkg::SBDSK_OP_SUB_ACC
        || req.op == sbdsk_pkg::SBDSK_OP_SUB_MEM;

    sub_acc_result_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        accept && req.op == sbdsk_pkg::SBDSK_OP_SUB_ACC |=> acc == $past(chk_full[7:0]) && done)
        else $error("accumulator subtract result wrong");

    sub_carry_flag_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        accept && (req.op == sbdsk_pkg::SBDSK_OP_SUB_ACC || req.op == sbdsk_pkg::SBDSK_OP_SUB_MEM)
        |=> flags.carry_flag == !$past(chk_full[8]))
        else $error("carry after subtract wrong");

    sub_mem_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        accept && req.op == sbdsk_pkg::SBDSK_OP_SUB_MEM |=> mem_wr.we
        && mem_wr.wdata == $past(chk_full[7:0]) && acc == $past(st_reg.acc))
        else $error("memory subtract write wrong");

    dec_skip_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        accept && req.op == sbdsk_pkg::SBDSK_OP_DEC_SKIP |=> mem_wr.we
        && mem_wr.wdata == $past(req.operand) - sbdsk_pkg::BYTE_ONE
        && skip_next == ($past(req.operand) == sbdsk_pkg::BYTE_ONE))
        else $error("decrement skip wrong");

    skip_dummy_cycle_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        skip_next |-> busy && !done ##1 !busy && done)
        else $error("skip did not take one dummy cycle");

    dec_flags_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        accept && req.op == sbdsk_pkg::SBDSK_OP_DEC_SKIP |=> $stable(flags))
        else $error("decrement skip changed flags");

    sub_zero_flag_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        accept && req.op == sbdsk_pkg::SBDSK_OP_SUB_ACC
        |=> flags.zero_flag == (acc == sbdsk_pkg::BYTE_ZERO))
        else $error("zero flag wrong");

    no_skip_single_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        accept && req.op == sbdsk_pkg::SBDSK_OP_DEC_SKIP && req.operand != sbdsk_pkg::BYTE_ONE
        |=> done && !busy)
        else $error("non-zero decrement should finish in one cycle");

    sub_overflow_flag_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        accept && is_sub |=> flags.overflow_flag == $past(chk_ovf))
        else $error("overflow flag after subtract wrong");

    sub_aux_carry_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        accept && is_sub |=> flags.auxiliary_carry_flag == !$past(chk_low[sbdsk_pkg::NIB_W]))
        else $error("aux carry after subtract wrong");

    mem_zero_flag_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        accept && req.op == sbdsk_pkg::SBDSK_OP_SUB_MEM
        |=> flags.zero_flag == (mem_wr.wdata == sbdsk_pkg::BYTE_ZERO))
        else $error("zero flag after memory subtract wrong");

    mem_write_addr_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        accept && (req.op == sbdsk_pkg::SBDSK_OP_SUB_MEM || req.op == sbdsk_pkg::SBDSK_OP_DEC_SKIP)
        |=> mem_wr.addr == $past(req.addr))
        else $error("write-back address wrong");

    sub_mem_single_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        accept && req.op == sbdsk_pkg::SBDSK_OP_SUB_MEM
        |=> done && !busy && !skip_next)
        else $error("memory subtract should finish in one cycle");

    acc_no_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        accept && req.op == sbdsk_pkg::SBDSK_OP_SUB_ACC |=> !mem_wr.we && !skip_next)
        else $error("accumulator subtract touched memory");

    dec_acc_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        accept && req.op == sbdsk_pkg::SBDSK_OP_DEC_SKIP |=> $stable(acc))
        else $error("decrement skip changed accumulator");

    skip_write_zero_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        skip_next |-> mem_wr.we && mem_wr.wdata == sbdsk_pkg::BYTE_ZERO)
        else $error("skip without a zero write-back");

    skip_late_done_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        accept && req.op == sbdsk_pkg::SBDSK_OP_DEC_SKIP && req.operand == sbdsk_pkg::BYTE_ONE
        |=> !done && busy)
        else $error("skipping decrement finished too early");

    busy_after_skip_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        busy |-> skip_next)
        else $error("busy without a skip");

    skip_one_pulse_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        skip_next |=> !skip_next && !mem_wr.we)
        else $error("skip pulse longer than one cycle");

    dummy_refuse_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        busy |=> !busy && !mem_wr.we && !skip_next && $stable(acc) && $stable(flags))
        else $error("request taken during the dummy cycle");

    op_none_idle_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        accept && req.op == sbdsk_pkg::SBDSK_OP_NONE
        |=> !done && !mem_wr.we && $stable(acc) && $stable(flags))
        else $error("empty request changed state");

    reset_clear_a: assert property (@(posedge clk_sys)
        !reset_n ##1 !reset_n |-> !busy && !done && !skip_next && !mem_wr.we
        && acc == sbdsk_pkg::ACC_RESET && flags == '0)
        else $error("outputs not cleared in reset");
endmodule
`default_nettype wire

//--- tb/sbdsk_mem_model.sv
// data memory model that stores the unit's write-backs
`timescale 1ns/1ps
`default_nettype none
module sbdsk_mem_model (
    input wire logic clk_sys,
    input wire sbdsk_pkg::sbdsk_mem_wr_s mem_wr
);
    logic [7:0] mem [256];
    // each byte starts equal to its own address
    initial for (int i = 0; i < 256; i++) mem[i] = 8'(i);
    always @(posedge clk_sys) begin
        if (mem_wr.we === 1'b1) mem[mem_wr.addr] <= mem_wr.wdata;
    end
endmodule
`default_nettype wire

//--- tb/subtract_borrow_and_decrement_skip_tb.sv
// self-checking bench for the subtract-borrow / decrement-skip unit
`timescale 1ns/1ps
`default_nettype none
module subtract_borrow_and_decrement_skip_tb;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic busy, done, skip_next;
    logic skip_seen = 1'b0;
    logic [7:0] acc;
    logic [7:0] m_acc = 8'h00;
    sbdsk_pkg::sbdsk_req_s req = '0;
    sbdsk_pkg::sbdsk_flags_s flags;
    sbdsk_pkg::sbdsk_flags_s m_fl = '0;
    sbdsk_pkg::sbdsk_mem_wr_s mem_wr;
    logic [12:0] res_q[$];
    logic [15:0] wr_q[$];
    int n_fail = 0;
    int compares = 0;
    always #2.5 clk_sys = ~clk_sys;
    sbdsk_unit DUT (.clk_sys(clk_sys), .reset_n(reset_n), .req(req), .busy(busy), .done(done),
        .skip_next(skip_next), .acc(acc), .flags(flags), .mem_wr(mem_wr));
    sbdsk_mem_model partner (.clk_sys(clk_sys), .mem_wr(mem_wr));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // drives one request and notes the expected results; gap idles after it
    task automatic issue(input sbdsk_pkg::sbdsk_op_e op, input logic [7:0] a, input int gap);
        logic [8:0] d;
        logic [4:0] h;
        logic [7:0] b;
        // read after the previous write-back has landed in memory
        #1 b = partner.mem[a];
        req = '{1'b1, op, a, b};
        if (op == sbdsk_pkg::SBDSK_OP_DEC_SKIP) begin
            d = {1'b0, b} - 9'h001;
            wr_q.push_back({a, d[7:0]});
            res_q.push_back({m_acc, m_fl, d[7:0] == 8'h00});
        end else if (op != sbdsk_pkg::SBDSK_OP_NONE) begin
            d = {1'b0, m_acc} - {1'b0, b} - {8'h00, ~m_fl.carry_flag};
            h = {1'b0, m_acc[3:0]} - {1'b0, b[3:0]} - {4'h0, ~m_fl.carry_flag};
            m_fl = '{(m_acc[7] != b[7]) && (d[7] != m_acc[7]), d[7:0] == 8'h00, ~h[4], ~d[8]};
            if (op == sbdsk_pkg::SBDSK_OP_SUB_ACC) m_acc = d[7:0];
            else wr_q.push_back({a, d[7:0]});
            res_q.push_back({m_acc, m_fl, 1'b0});
        end
        @(posedge clk_sys);
        repeat (gap) begin
            #1 req.valid = 1'b0;
            @(posedge clk_sys);
        end
    endtask
    always @(negedge clk_sys) begin
        if (reset_n) begin
            if (mem_wr.we === 1'b1) check({mem_wr.addr, mem_wr.wdata}, wr_q.size() ? wr_q.pop_front() : 'x);
            if (skip_next === 1'b1) begin
                skip_seen = 1'b1;
                check({15'h0, busy}, 16'h0001);
            end
            if (done === 1'b1) begin
                check({3'h0, acc, flags, skip_seen}, res_q.size() ? {3'h0, res_q.pop_front()} : 'x);
                skip_seen = 1'b0;
            end
        end
    end
    initial begin
        #20000;
        n_fail++;
        finish_test();
    end
    initial begin
        sbdsk_pkg::sbdsk_op_e op;
        void'($urandom(32'h1C5CA9FB));
        repeat (12) @(posedge clk_sys);
        #1 reset_n = 1'b1;
        @(posedge clk_sys);
        issue(sbdsk_pkg::SBDSK_OP_SUB_ACC, 8'h10, 0);
        issue(sbdsk_pkg::SBDSK_OP_SUB_ACC, 8'h00, 0);
        issue(sbdsk_pkg::SBDSK_OP_SUB_MEM, 8'h80, 1);
        issue(sbdsk_pkg::SBDSK_OP_DEC_SKIP, 8'h01, 0);
        // request during the dummy cycle is dropped
        #1 req = '{1'b1, sbdsk_pkg::SBDSK_OP_SUB_ACC, 8'h05, 8'h33};
        @(posedge clk_sys);
        #1 req.valid = 1'b0;
        @(posedge clk_sys);
        issue(sbdsk_pkg::SBDSK_OP_DEC_SKIP, 8'h02, 1);
        issue(sbdsk_pkg::SBDSK_OP_NONE, 8'h03, 1);
        $display("test directed done");
        for (int i = 0; i < 300; i++) begin
            op = sbdsk_pkg::sbdsk_op_e'($urandom_range(3, 0));
            issue(op, 8'($urandom), int'(op[1]));
        end
        #1 req.valid = 1'b0;
        repeat (4) @(posedge clk_sys);
        check(16'(res_q.size() + wr_q.size()), 16'h0000);
        $display("test random done");
        finish_test();
    end
endmodule
`default_nettype wire
